// File: flr_hist_if.sv
// bundle between the recorder core and its history store
`timescale 1ns/1ps
interface flr_hist_if;
	import flr_pkg::*;
	logic wr_en; // append one record
	logic [FLR_REC_BITS-1:0] wr_rec; // record, byte 0 in the top bits
	logic [2:0] rec_a; // 0 = newest, port a
	logic [4:0] byte_a; // byte within record, port a
	logic [7:0] data_a;
	logic [2:0] rec_b; // port b
	logic [4:0] byte_b;
	logic [7:0] data_b;
	modport core (output wr_en, wr_rec, rec_a, byte_a, rec_b, byte_b, input data_a, data_b);
	modport store (input wr_en, wr_rec, rec_a, byte_a, rec_b, byte_b, output data_a, data_b);
endinterface

// File: flr_history.sv
// rolling store of the newest conversion-cycle records
`timescale 1ns/1ps
module flr_history #(
	parameter int DEPTH = flr_pkg::FLR_REC_COUNT
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	flr_hist_if.store hist
);
	import flr_pkg::*;
	if (DEPTH < 2 || DEPTH > 7) begin : g_bad_depth
		$error("flr_history: DEPTH out of range");
	end
	logic [FLR_REC_BITS-1:0] mem_q [DEPTH]; // record slots
	logic [2:0] wptr_q; // next slot to fill

	// newest-first index to physical slot
	function automatic logic [2:0] slot_of(input logic [2:0] wp, input logic [2:0] age);
		logic [3:0] s;
		s = {1'b0, wp} + 4'(DEPTH) - 4'd1 - {1'b0, age};
		if (s >= 4'(DEPTH)) s = s - 4'(DEPTH);
		return s[2:0];
	endfunction

	// byte select; byte 0 sits in the top bits
	function automatic logic [7:0] pick(input logic [FLR_REC_BITS-1:0] r, input logic [4:0] b);
		return r[FLR_REC_BITS - 1 - 8 * int'(b) -: 8];
	endfunction

	wire [2:0] slot_a = slot_of(wptr_q, hist.rec_a);
	wire [2:0] slot_b = slot_of(wptr_q, hist.rec_b);
	assign hist.data_a = pick(mem_q[slot_a], hist.byte_a);
	assign hist.data_b = pick(mem_q[slot_b], hist.byte_b);

	// circular write; the core stops issuing writes once frozen
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wptr_q <= 3'h0;
		end else if (hist.wr_en) begin
			wptr_q <= (wptr_q == 3'(DEPTH - 1)) ? 3'h0 : wptr_q + 3'h1;
		end
	end

	// slot storage, no reset needed on data
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_slot
			always_ff @(posedge clk_in) begin
				if (hist.wr_en && wptr_q == 3'(i)) begin
					mem_q[i] <= hist.wr_rec;
				end
			end
		end
	endgenerate
endmodule

// File: flr_nvm_model.sv
// behavioural nonvolatile memory that serves the recorder's copy and scan
`timescale 1ns/1ps
module flr_nvm_model (
	input wire logic clk_in,
	input wire logic nvm_wr_in,
	input wire logic nvm_rd_in,
	input wire logic [7:0] nvm_addr_in,
	input wire logic [7:0] nvm_wdata_in,
	output logic [7:0] nvm_rdata_out
);
	logic [7:0] mem [0:255]; // starts erased, survives every reset
	// erased cells read as all ones
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'hFF;
		end
	end
	// one byte written per cycle
	always @(posedge clk_in) begin
		if (nvm_wr_in) mem[nvm_addr_in] <= nvm_wdata_in;
	end
	// data stand while the read strobe does; otherwise inverted, so mistimed sampling shows up
	assign nvm_rdata_out = nvm_rd_in ? mem[nvm_addr_in] : ~mem[nvm_addr_in];
endmodule

// File: flr_pkg.sv
// shared constants for the fault-log recorder
package flr_pkg;
	// register byte addresses
	localparam logic [7:0] FLR_ADDR_CTRL = 8'h00;
	localparam logic [7:0] FLR_ADDR_STATUS = 8'h04;
	localparam logic [7:0] FLR_ADDR_LOG_COUNT = 8'h08;
	localparam logic [7:0] FLR_ADDR_LOG_DATA = 8'h0C;
	localparam logic [7:0] FLR_ADDR_PIN_CFG = 8'h10;
	// control register bit positions (self-clearing commands)
	localparam int FLR_CTRL_CLEAR_FAULTS = 0;
	localparam int FLR_CTRL_ERASE_LOG = 1;
	localparam int FLR_CTRL_MANUAL_STORE = 2;
	localparam int FLR_CTRL_CLEAR_PEAKS = 3;
	// status register bit positions
	localparam int FLR_STAT_LOG_PRESENT = 0;
	localparam int FLR_STAT_VALID_LOG = 1;
	localparam int FLR_STAT_BLOCKED = 2;
	localparam int FLR_STAT_COPY_BUSY = 3;
	localparam int FLR_STAT_HOT_WAIT = 4;
	localparam int FLR_STAT_ADC_LSB = 8;
	// log layout
	localparam int FLR_LOG_LEN = 147;
	localparam int FLR_HDR_LAST = 26;
	localparam int FLR_REC_FIRST = 27;
	localparam int FLR_REC_BYTES = 20;
	localparam int FLR_REC_COUNT = 6;
	localparam int FLR_REC_BITS = FLR_REC_BYTES * 8;
	localparam logic [7:0] FLR_CODE_MANUAL = 8'hFF;
	// die temperature thresholds in degrees C
	localparam logic [7:0] FLR_TEMP_HOT = 8'h82;
	localparam logic [7:0] FLR_TEMP_COOL = 8'h7D;
	// reset values
	localparam logic [47:0] FLR_TS_RESET = 48'h0000_0000_0000;
	localparam logic [15:0] FLR_PEAK_RESET = 16'h0000;
	localparam logic [1:0] FLR_PIN_CFG_RESET = 2'h0;
endpackage

// File: flr_recorder.sv
// fault-log recorder: rolling history, freeze, nonvolatile copy, block read
// Notes on behaviour
// - keep refreshing history while no fault
// - fault freezes log, readable, copied to memory; peak bytes 11-20 keep tracking after the freeze
// - hot die postpones copy until cooled
// - fault pins never start a capture
// - power-up scan sets valid-log flag
// - stored log blocks capture until clear-faults
// - log read is fixed 147-byte block
// - no log gives byte count zero
// - record per cycle, six newest kept
// - finish cycle, note converting input
// - header bytes 0-26, fault record 27-46
// - five older records 47-146, oldest last
// - four-character preface when log exists
// - byte 4 holds the cause code
// - bytes 5-10 timestamp, low byte first
// - bytes 11-20 peaks, high byte first
// - bytes 21-26 temperatures at last event
// - pin faults passed on, no deglitch
// - power-good pin shows output in regulation
// - cause in low nibble, channel high nibble
// - record field order, high byte first
`timescale 1ns/1ps
module flr_recorder #(
	parameter logic [31:0] PREFACE = 32'h5846_3031, // arbitrary four-character value
	parameter int REC_COUNT = flr_pkg::FLR_REC_COUNT
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// monitor conversion stream
	input wire logic rec_valid_in,
	input wire logic [flr_pkg::FLR_REC_BITS-1:0] rec_data_in,
	input wire logic [4:0] adc_input_in,
	input wire logic [15:0] ext_temp0_in,
	input wire logic [15:0] ext_temp1_in,
	input wire logic [15:0] die_temp_word_in,
	input wire logic [7:0] die_temp_in,
	// channel-disabling fault from internal protection
	input wire logic fault_in,
	input wire logic [3:0] fault_cause_in,
	input wire logic fault_chan_in,
	// shared timing clock
	input wire logic share_clk_in,
	// nonvolatile memory port
	output logic nvm_wr_out,
	output logic nvm_rd_out,
	output logic [7:0] nvm_addr_out,
	output logic [7:0] nvm_wdata_out,
	input wire logic [7:0] nvm_rdata_in,
	// general fault pins
	input wire logic [1:0] fault_pin_in,
	output logic [1:0] fault_pin_out,
	output logic [1:0] fault_pin_oe_out,
	input wire logic [1:0] in_regulation_in,
	input wire logic [1:0] master_phase_in,
	output logic [1:0] ext_fault_out,
	output logic valid_log_out
);
	import flr_pkg::*;
	if (REC_COUNT != FLR_REC_COUNT) begin : g_bad_count
		$error("flr_recorder: log layout needs six records");
	end

	typedef enum {FLR_SCAN0, FLR_SCAN1, FLR_SCAN2, FLR_RUN, FLR_COPY} flr_state_t;

	flr_hist_if hist(); // history bundle
	flr_history #(.DEPTH(REC_COUNT)) u_hist (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.hist(hist)
	);

	// pin and timing clock synchronisers; pins enter inverted so reset reads as idle
	logic [2:0] sync_q;
	flr_sync #(.WIDTH(3)) u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in({share_clk_in, ~fault_pin_in}),
		.sync_out(sync_q)
	);

	flr_state_t state_q; // sequencer
	logic share_prev_q; // share clock, one cycle older
	logic [47:0] ts_q; // running share-clock count
	logic frozen_q; // history no longer updated
	logic log_present_q; // frozen log readable
	logic stored_valid_q; // valid log found at power-up
	logic pending_q; // capture waits for cycle end
	logic copy_req_q; // frozen log not yet copied
	logic hot_q; // die too hot for memory writes
	logic [7:0] code_q; // cause of the log
	logic [47:0] ts_snap_q; // count at the fault
	logic [4:0] adc_snap_q; // input converting at the fault
	logic [15:0] peak_q [5]; // vout0, vout1, iout0, iout1, vin
	logic [15:0] temp_q [3]; // ext0, ext1, die, at last event
	logic [7:0] byte_idx_q; // block-read position
	logic [7:0] copy_idx_q; // copy position
	logic [7:0] scan0_q; // first preface byte found
	logic [1:0] pin_cfg_q; // 1 = power-good output
	logic [31:0] rdata_q;
	logic nvm_wr_q;
	logic nvm_rd_q;
	logic [7:0] nvm_addr_q;
	logic [7:0] nvm_wdata_q;
	logic [1:0] pin_oe_q;
	logic [1:0] ext_fault_q;

	// register decode
	wire wr_ctrl = reg_wr_in && reg_addr_in == FLR_ADDR_CTRL;
	wire wr_cfg = reg_wr_in && reg_addr_in == FLR_ADDR_PIN_CFG;
	wire rd_count = reg_rd_in && reg_addr_in == FLR_ADDR_LOG_COUNT;
	wire rd_data = reg_rd_in && reg_addr_in == FLR_ADDR_LOG_DATA;
	wire cmd_clear = wr_ctrl && reg_wdata_in[FLR_CTRL_CLEAR_FAULTS];
	wire cmd_erase = wr_ctrl && reg_wdata_in[FLR_CTRL_ERASE_LOG];
	wire cmd_store = wr_ctrl && reg_wdata_in[FLR_CTRL_MANUAL_STORE];
	wire cmd_peaks = wr_ctrl && reg_wdata_in[FLR_CTRL_CLEAR_PEAKS];

	// capture gating: stored log or frozen log blocks a new one
	wire can_capture = (state_q == FLR_RUN) && !stored_valid_q && !frozen_q && !pending_q;
	// only the internal fault line or a manual store starts a capture; pins do not
	wire start_fault = can_capture && fault_in;
	wire start_manual = can_capture && !fault_in && cmd_store;
	wire hist_write = rec_valid_in && !frozen_q && state_q != FLR_SCAN0;
	wire freeze_now = hist_write && pending_q;
	wire share_edge = sync_q[2] && !share_prev_q;
	wire [7:0] cause_code = {3'h0, fault_chan_in, fault_cause_in};

	// header byte builder, indexes 0..26
	function automatic logic [7:0] hdr_byte(input logic [7:0] i);
		logic [7:0] b;
		b = 8'h00;
		if (i < 8'd4) b = PREFACE[31 - 8 * int'(i) -: 8];
		else if (i == 8'd4) b = code_q;
		else if (i < 8'd11) b = ts_snap_q[8 * (int'(i) - 5) +: 8];
		else if (i < 8'd21) b = peak_q[(int'(i) - 11) / 2][((int'(i) - 11) % 2 == 0) ? 15 : 7 -: 8];
		else b = temp_q[(int'(i) - 21) / 2][((int'(i) - 21) % 2 == 0) ? 15 : 7 -: 8];
		return b;
	endfunction

	// split a record-area index into record age and byte
	function automatic logic [7:0] rec_part(input logic [7:0] i, input logic want_rec);
		logic [7:0] off;
		off = i - 8'(FLR_REC_FIRST);
		return want_rec ? 8'(off / 8'(FLR_REC_BYTES)) : 8'(off % 8'(FLR_REC_BYTES));
	endfunction

	wire [7:0] idx_a = byte_idx_q;
	wire [7:0] idx_b = copy_idx_q;
	wire [7:0] rec_a_w = rec_part(idx_a, 1'b1);
	wire [7:0] byte_a_w = rec_part(idx_a, 1'b0);
	wire [7:0] rec_b_w = rec_part(idx_b, 1'b1);
	wire [7:0] byte_b_w = rec_part(idx_b, 1'b0);
	assign hist.wr_en = hist_write;
	assign hist.wr_rec = rec_data_in;
	assign hist.rec_a = rec_a_w[2:0];
	assign hist.byte_a = byte_a_w[4:0];
	assign hist.rec_b = rec_b_w[2:0];
	assign hist.byte_b = byte_b_w[4:0];
	wire [7:0] log_byte_a = (idx_a <= 8'(FLR_HDR_LAST)) ? hdr_byte(idx_a) : hist.data_a;
	wire [7:0] log_byte_b = (idx_b <= 8'(FLR_HDR_LAST)) ? hdr_byte(idx_b) : hist.data_b;
	wire log_exists = log_present_q || stored_valid_q;
	// fixed block length, zero count with no log
	wire [7:0] count_val = log_exists ? 8'(FLR_LOG_LEN) : 8'h00;
	wire [31:0] status_val = {19'h0, adc_snap_q, 3'h0, hot_q, state_q == FLR_COPY,
		!can_capture, stored_valid_q, log_present_q};
	wire [31:0] read_mux =
		(reg_addr_in == FLR_ADDR_STATUS) ? status_val :
		(reg_addr_in == FLR_ADDR_LOG_COUNT) ? {24'h0, count_val} :
		(reg_addr_in == FLR_ADDR_LOG_DATA) ? {24'h0, log_exists ? log_byte_a : 8'h00} :
		(reg_addr_in == FLR_ADDR_PIN_CFG) ? {30'h0, pin_cfg_q} : 32'h0000_0000;
	// hysteresis on die temperature for memory writes
	wire hot_d = hot_q ? !(die_temp_in < FLR_TEMP_COOL) : (die_temp_in > FLR_TEMP_HOT);

	// bus read data, valid the cycle after the strobe only
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) rdata_q <= 32'h0000_0000;
		else rdata_q <= reg_rd_in ? read_mux : 32'h0000_0000;
	end

	// block-read position: count read restarts, data read advances
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			byte_idx_q <= 8'h00;
		end else if (rd_count) begin
			byte_idx_q <= 8'h00;
		end else if (rd_data && byte_idx_q != 8'(FLR_LOG_LEN - 1)) begin
			byte_idx_q <= byte_idx_q + 8'h01;
		end
	end

	// share-clock timestamp counter
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			share_prev_q <= 1'b0;
			ts_q <= FLR_TS_RESET;
		end else begin
			share_prev_q <= sync_q[2];
			if (share_edge) ts_q <= ts_q + 48'h0000_0000_0001;
		end
	end

	// capture and freeze control
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pending_q <= 1'b0;
			frozen_q <= 1'b0;
			log_present_q <= 1'b0;
			copy_req_q <= 1'b0;
			code_q <= 8'h00;
			ts_snap_q <= FLR_TS_RESET;
			adc_snap_q <= 5'h00;
		end else begin
			if (start_fault || start_manual) begin
				pending_q <= 1'b1;
				code_q <= start_fault ? cause_code : FLR_CODE_MANUAL;
				ts_snap_q <= ts_q;
				adc_snap_q <= adc_input_in;
			end else if (freeze_now) begin
				// cycle in progress finished, stop updating
				pending_q <= 1'b0;
				frozen_q <= 1'b1;
				log_present_q <= 1'b1;
				copy_req_q <= 1'b1;
			end else if (cmd_erase && !pending_q) begin
				// erase unfreezes the history
				frozen_q <= 1'b0;
				log_present_q <= 1'b0;
				copy_req_q <= 1'b0;
			end else if (state_q == FLR_COPY && copy_idx_q == 8'(FLR_LOG_LEN - 1) && !hot_q) begin
				copy_req_q <= 1'b0;
			end
		end
	end

	// peak tracking and last-event temperatures
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || cmd_peaks) begin
			for (int k = 0; k < 5; k++) peak_q[k] <= FLR_PEAK_RESET;
		end else if (rec_valid_in) begin
			for (int k = 0; k < 5; k++) begin
				if (rec_data_in[FLR_REC_BITS - 1 - 16 * k -: 16] > peak_q[k]) begin
					peak_q[k] <= rec_data_in[FLR_REC_BITS - 1 - 16 * k -: 16];
				end
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			for (int k = 0; k < 3; k++) temp_q[k] <= 16'h0000;
		end else if (hist_write) begin
			temp_q[0] <= ext_temp0_in;
			temp_q[1] <= ext_temp1_in;
			temp_q[2] <= die_temp_word_in;
		end
	end

	// power-up scan, then run, copy to memory when cool
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= FLR_SCAN0;
			stored_valid_q <= 1'b0;
			scan0_q <= 8'h00;
			copy_idx_q <= 8'h00;
			hot_q <= 1'b0;
			nvm_wr_q <= 1'b0;
			nvm_rd_q <= 1'b0;
			nvm_addr_q <= 8'h00;
			nvm_wdata_q <= 8'h00;
		end else begin
			hot_q <= hot_d;
			nvm_wr_q <= 1'b0;
			nvm_rd_q <= 1'b0;
			if (cmd_clear) stored_valid_q <= 1'b0;
			case (state_q)
				FLR_SCAN0: begin
					nvm_rd_q <= 1'b1;
					nvm_addr_q <= 8'h00;
					state_q <= FLR_SCAN1;
				end
				FLR_SCAN1: begin
					// memory answers while the read pulse stands
					nvm_rd_q <= 1'b1;
					nvm_addr_q <= 8'h01;
					scan0_q <= nvm_rdata_in;
					state_q <= FLR_SCAN2;
				end
				FLR_SCAN2: begin
					stored_valid_q <= {scan0_q, nvm_rdata_in} == PREFACE[31:16];
					state_q <= FLR_RUN;
				end
				FLR_RUN: begin
					copy_idx_q <= 8'h00;
					if (copy_req_q && !hot_q) state_q <= FLR_COPY;
				end
				FLR_COPY: begin
					if (!hot_q) begin
						// one byte per cycle, waits in place while hot
						nvm_wr_q <= 1'b1;
						nvm_addr_q <= copy_idx_q;
						nvm_wdata_q <= log_byte_b;
						if (copy_idx_q == 8'(FLR_LOG_LEN - 1)) state_q <= FLR_RUN;
						else copy_idx_q <= copy_idx_q + 8'h01;
					end
				end
				default: state_q <= FLR_RUN;
			endcase
		end
	end

	// fault pins: pass-through without filtering, or power-good output
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pin_cfg_q <= FLR_PIN_CFG_RESET;
			pin_oe_q <= 2'h0;
			ext_fault_q <= 2'h0;
		end else begin
			if (wr_cfg) pin_cfg_q <= reg_wdata_in[1:0];
			// low pin means fault; no deglitch beyond the synchroniser
			ext_fault_q <= ~pin_cfg_q & sync_q[1:0];
			// pull low while a master output is out of regulation
			pin_oe_q <= pin_cfg_q & master_phase_in & ~in_regulation_in;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign nvm_wr_out = nvm_wr_q;
	assign nvm_rd_out = nvm_rd_q;
	assign nvm_addr_out = nvm_addr_q;
	assign nvm_wdata_out = nvm_wdata_q;
	assign fault_pin_out = 2'h0; // open drain, only ever drives low
	assign fault_pin_oe_out = pin_oe_q;
	assign ext_fault_out = ext_fault_q;
	assign valid_log_out = stored_valid_q;
endmodule

// File: flr_recorder_props.sv
// port-level checker for the fault-log recorder
`timescale 1ns/1ps
module flr_recorder_props #(
	parameter logic [31:0] PREFACE = 32'h5846_3031,
	parameter int REC_COUNT = flr_pkg::FLR_REC_COUNT
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic [7:0] die_temp_in,
	input wire logic nvm_wr_out,
	input wire logic nvm_rd_out,
	input wire logic [7:0] nvm_addr_out,
	input wire logic [1:0] fault_pin_in,
	input wire logic [1:0] fault_pin_out,
	input wire logic [1:0] fault_pin_oe_out,
	input wire logic [1:0] in_regulation_in,
	input wire logic [1:0] master_phase_in,
	input wire logic [1:0] ext_fault_out,
	input wire logic valid_log_out
);
	import flr_pkg::*;
	logic [1:0] cfg_q; // shadow of the pin mode register
	logic [3:0] cyc_q; // cycles since reset release, saturating
	wire cfg_wr = reg_wr_in && (reg_addr_in == FLR_ADDR_PIN_CFG); // pin mode write
	// shadow pin mode and count cycles after reset
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) cfg_q <= FLR_PIN_CFG_RESET;
		else if (cfg_wr) cfg_q <= reg_wdata_in[1:0];
		if (!rst_n_in) cyc_q <= 4'h0;
		else if (cyc_q != 4'hF) cyc_q <= cyc_q + 4'h1;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data not zero outside answer cycle");
	pin_level_a: assert property (fault_pin_out == 2'h0)
		else $error("fault pin driven high");
	ext_seen_a: assert property ((!fault_pin_in[0] && !cfg_q[0])[*5] |-> ext_fault_out[0])
		else $error("low input pin not passed on");
	ext_idle_a: assert property ((fault_pin_in[0])[*5] |-> !ext_fault_out[0])
		else $error("high input pin reported as fault");
	pg_low_a: assert property ((cfg_q[1] && master_phase_in[1]
		&& !in_regulation_in[1])[*3] |-> fault_pin_oe_out[1])
		else $error("power-good not pulled low out of regulation");
	pg_free_a: assert property ((cfg_q[1] && master_phase_in[1]
		&& in_regulation_in[1])[*3] |-> !fault_pin_oe_out[1])
		else $error("power-good pulled low in regulation");
	hot_hold_a: assert property ((die_temp_in > FLR_TEMP_HOT)[*4] |-> !nvm_wr_out)
		else $error("memory written while die hot");
	copy_step_a: assert property (nvm_wr_out && $past(nvm_wr_out)
		|-> nvm_addr_out == $past(nvm_addr_out) + 8'h01)
		else $error("copy address not consecutive");
	copy_bound_a: assert property (nvm_wr_out |-> nvm_addr_out <= 8'h92)
		else $error("copy beyond log length");
	scan_only_a: assert property (nvm_rd_out |-> cyc_q <= 4'h3)
		else $error("memory read outside power-up scan");
	valid_rise_a: assert property ($rose(valid_log_out) |-> cyc_q <= 4'h4)
		else $error("valid flag raised after scan");
	clear_valid_a: assert property (reg_wr_in && reg_addr_in == FLR_ADDR_CTRL
		&& reg_wdata_in[FLR_CTRL_CLEAR_FAULTS] && cyc_q > 4'h2 |=> !valid_log_out)
		else $error("clear faults left valid flag set");
	valid_c: cover property ($rose(valid_log_out));
	copy_end_c: cover property (nvm_wr_out && nvm_addr_out == 8'h92);
	ext_c: cover property ($rose(ext_fault_out[0]));
endmodule
bind flr_recorder flr_recorder_props #(.PREFACE(PREFACE), .REC_COUNT(REC_COUNT)) u_flr_recorder_props (.*);

// File: flr_recorder_tb.sv
// self-checking bench for the fault-log recorder
`timescale 1ns/1ps
module flr_recorder_tb;
	import flr_pkg::*;
	localparam logic [31:0] PREF = 32'h5846_3031; // arbitrary preface value
	localparam int NSHARE = 5; // share clock edges before the fault
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic rec_valid_in = 1'b0;
	logic [FLR_REC_BITS-1:0] rec_data_in = '0;
	logic [4:0] adc_input_in = 5'h07;
	logic [7:0] die_temp_in = 8'h19;
	logic fault_in = 1'b0;
	logic [3:0] fault_cause_in = 4'h1;
	logic fault_chan_in = 1'b1;
	logic share_clk_in = 1'b0;
	logic nvm_wr_out;
	logic nvm_rd_out;
	logic [7:0] nvm_addr_out;
	logic [7:0] nvm_wdata_out;
	logic [7:0] nvm_rdata_in;
	logic pin0_ext = 1'b1; // outside driver on pin 0
	logic [15:0] temp0 = 16'h1234; // outside temperature sensor 0
	logic [1:0] fault_pin_in;
	logic [1:0] fault_pin_out;
	logic [1:0] fault_pin_oe_out;
	logic [1:0] ext_fault_out;
	logic [1:0] in_regulation_in = 2'h0;
	logic [1:0] master_phase_in = 2'h2;
	logic valid_log_out;
	int fails = 0;
	int n_tests = 0;
	logic [31:0] d; // last read data
	// open-drain pins with pull-ups
	assign fault_pin_in = {~fault_pin_oe_out[1], pin0_ext & ~fault_pin_oe_out[0]};
	always #20 clk_in = ~clk_in;
	flr_recorder #(.PREFACE(PREF)) u_flr_recorder (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rec_valid_in(rec_valid_in),
		.rec_data_in(rec_data_in), .adc_input_in(adc_input_in), .ext_temp0_in(temp0),
		.ext_temp1_in(16'h5678), .die_temp_word_in(16'h9ABC), .die_temp_in(die_temp_in),
		.fault_in(fault_in), .fault_cause_in(fault_cause_in), .fault_chan_in(fault_chan_in),
		.share_clk_in(share_clk_in), .nvm_wr_out(nvm_wr_out), .nvm_rd_out(nvm_rd_out),
		.nvm_addr_out(nvm_addr_out), .nvm_wdata_out(nvm_wdata_out), .nvm_rdata_in(nvm_rdata_in),
		.fault_pin_in(fault_pin_in), .fault_pin_out(fault_pin_out),
		.fault_pin_oe_out(fault_pin_oe_out), .in_regulation_in(in_regulation_in),
		.master_phase_in(master_phase_in), .ext_fault_out(ext_fault_out),
		.valid_log_out(valid_log_out));
	flr_nvm_model u_flr_nvm_model (.clk_in(clk_in), .nvm_wr_in(nvm_wr_out),
		.nvm_rd_in(nvm_rd_out), .nvm_addr_in(nvm_addr_out), .nvm_wdata_in(nvm_wdata_out),
		.nvm_rdata_out(nvm_rdata_in));
	// counts and verdict, the single end of the run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask
	// bounded poll of one status bit; running out ends the run
	task automatic wait_stat(input int b, input logic v);
		int i;
		for (i = 0; i < 400; i++) begin
			rd(FLR_ADDR_STATUS);
			if (d[b] === v) break;
		end
		if (i == 400) begin
			chk({31'h0, d[b]}, {31'h0, v});
			report_and_stop();
		end
	endtask
	// record byte b of cycle k: cycle in the top bits, byte index below
	function automatic logic [7:0] rb(input logic [2:0] k, input int b);
		return {k, 5'(b)};
	endfunction
	task automatic push(input logic [2:0] k);
		@(posedge clk_in);
		for (int b = 0; b < 20; b++) rec_data_in[159-8*b -: 8] <= rb(k, b);
		rec_valid_in <= 1'b1;
		@(posedge clk_in);
		rec_valid_in <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic fault_pulse();
		@(posedge clk_in);
		fault_in <= 1'b1;
		@(posedge clk_in);
		fault_in <= 1'b0;
	endtask
	// link clock runs only in bursts, 320 ns period
	task automatic share(input int n);
		repeat (n) begin
			@(posedge clk_in);
			share_clk_in <= 1'b1;
			repeat (4) @(posedge clk_in);
			share_clk_in <= 1'b0;
			repeat (3) @(posedge clk_in);
		end
	endtask
	// expected log byte after cycles 0..6 and fault cycle 7
	function automatic logic [7:0] exp_byte(input int i);
		logic [47:0] ts;
		logic [47:0] tp;
		ts = 48'(NSHARE);
		tp = 48'h1234_5678_9ABC;
		if (i < 4) return PREF[31-8*i -: 8];
		if (i == 4) return 8'h11;
		if (i < 11) return ts[8*(i-5) +: 8];
		if (i < 21) return rb(3'h7, i-11);
		if (i < 27) return tp[47-8*(i-21) -: 8];
		return rb(3'(7-(i-27)/20), (i-27)%20);
	endfunction
	initial begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(FLR_ADDR_LOG_COUNT);
		chk(d, 32'h0);
		rd(8'h44);
		chk(d, 32'h0);
		$display("test empty log done");
		// pin 0 fault input, pin 1 power-good output
		wr(FLR_ADDR_PIN_CFG, 32'h0000_0002);
		pin0_ext <= 1'b0;
		repeat (6) @(posedge clk_in);
		in_regulation_in <= 2'h2;
		#1;
		chk({30'h0, ext_fault_out}, 32'h1);
		repeat (4) @(posedge clk_in);
		#1;
		chk({31'h0, fault_pin_oe_out[1]}, 32'h0);
		@(posedge clk_in);
		in_regulation_in <= 2'h0;
		repeat (4) @(posedge clk_in);
		#1;
		chk({31'h0, fault_pin_oe_out[1]}, 32'h1);
		rd(FLR_ADDR_STATUS);
		chk({31'h0, d[FLR_STAT_LOG_PRESENT]}, 32'h0);
		pin0_ext <= 1'b1;
		$display("test pins done");
		// history, timestamp, hot die holding off the copy
		share(NSHARE);
		for (int k = 0; k < 7; k++) push(3'(k));
		die_temp_in <= 8'h83;
		fault_pulse();
		push(3'h7);
		temp0 <= 16'h0000; // after the freeze, must not reach the header
		push(3'h0);
		repeat (10) @(posedge clk_in);
		rd(FLR_ADDR_STATUS);
		chk({27'h0, d[12:8]}, 32'h7);
		chk({30'h0, d[FLR_STAT_HOT_WAIT], d[FLR_STAT_LOG_PRESENT]}, 32'h3);
		die_temp_in <= 8'h80;
		repeat (10) @(posedge clk_in);
		rd(FLR_ADDR_STATUS);
		chk({31'h0, d[FLR_STAT_HOT_WAIT]}, 32'h1);
		die_temp_in <= 8'h7C;
		wait_stat(FLR_STAT_HOT_WAIT, 1'b0);
		wait_stat(FLR_STAT_COPY_BUSY, 1'b0);
		rd(FLR_ADDR_LOG_COUNT);
		chk(d, 32'(FLR_LOG_LEN));
		for (int i = 0; i < 147; i++) begin
			rd(FLR_ADDR_LOG_DATA);
			chk(d, {24'h0, exp_byte(i)});
			chk({24'h0, u_flr_nvm_model.mem[i]}, {24'h0, exp_byte(i)});
		end
		rd(FLR_ADDR_LOG_DATA);
		chk(d, {24'h0, exp_byte(146)});
		$display("test capture and copy done");
		// power up again with the stored log in memory
		rst_n_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk({31'h0, valid_log_out}, 32'h1);
		rd(FLR_ADDR_STATUS);
		chk({30'h0, d[FLR_STAT_BLOCKED], d[FLR_STAT_VALID_LOG]}, 32'h3);
		fault_pulse();
		push(3'h5);
		rd(FLR_ADDR_STATUS);
		chk({31'h0, d[FLR_STAT_LOG_PRESENT]}, 32'h0);
		wr(FLR_ADDR_CTRL, 32'h0000_0001);
		#1;
		chk({31'h0, valid_log_out}, 32'h0);
		wr(FLR_ADDR_CTRL, 32'h0000_0002);
		wr(FLR_ADDR_CTRL, 32'h0000_000C);
		push(3'h2);
		wait_stat(FLR_STAT_LOG_PRESENT, 1'b1);
		rd(FLR_ADDR_LOG_COUNT);
		chk(d, 32'(FLR_LOG_LEN));
		repeat (5) rd(FLR_ADDR_LOG_DATA);
		chk(d, {24'h0, FLR_CODE_MANUAL});
		repeat (7) rd(FLR_ADDR_LOG_DATA);
		chk(d, {24'h0, rb(3'h2, 0)});
		$display("test stored log and manual store done");
		report_and_stop();
	end
endmodule

// File: flr_sync.sv
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
module flr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	if (WIDTH < 1) begin : g_bad_width
		$error("flr_sync: WIDTH must be at least 1");
	end
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q; // first stage, read only by the second
			logic stab_q;
			// plain two-stage chain
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					meta_q <= 1'b0;
					stab_q <= 1'b0;
				end else begin
					meta_q <= async_in[i];
					stab_q <= meta_q;
				end
			end
			assign sync_out[i] = stab_q;
		end
	endgenerate
endmodule
